// file: logic/charger_input_supervisor.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module charger_input_supervisor (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparators
   input wire charger_supervisor_pkg::cmp_t cmpRaw,
   // Charger control
   output logic chargeEnable,
   output charger_supervisor_pkg::ovp_sel_t ovpSelOut,
   output charger_supervisor_pkg::in_limit_t inputLimit,
   output charger_supervisor_pkg::chg_cur_t chargeCurrent,
   output logic chargeReduce,
   output charger_supervisor_pkg::path_t powerPath,
   // Interrupt
   output logic irqOutN
);

   // ****************************************
   // Declarations
   // ****************************************
   charger_supervisor_pkg::cmp_t cmpQ;
   charger_supervisor_pkg::ctrl_t ctrl_q;
   logic validQ;
   logic connectQ;
   logic disconnectQ;
   logic ovpLock_q;
   logic uvLock_q;
   logic inputIrqFlag_q;
   logic irqSet;
   logic accessStart;
   logic accessDone;
   logic ctrlHit;
   logic statusHit;
   logic statusReadDone;
   logic ctrlWriteDone;
   logic ovpHit;
   logic inputValidStatus;
   logic [31:0] readWord;

   function automatic logic [31:0] ctrl_word(
      input charger_supervisor_pkg::ctrl_t c);
      logic [31:0] w;
      w = '0;
      w[charger_supervisor_pkg::CTRL_OVP_LSB +: 2] = c.ovpSel;
      w[charger_supervisor_pkg::CTRL_STAT_EN_BIT] = c.statEn;
      w[charger_supervisor_pkg::CTRL_CON_EN_BIT] = c.conEn;
      w[charger_supervisor_pkg::CTRL_DIS_EN_BIT] = c.disEn;
      return w;
   endfunction

   // ****************************************
   // Comparator sampling
   // ****************************************
   input_edge_reg u_edge (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .cmpRaw(cmpRaw),
      .ovpSel(ctrl_q.ovpSel),
      .cmpQ(cmpQ),
      .validQ(validQ),
      .connectQ(connectQ),
      .disconnectQ(disconnectQ)
   );

   assign ovpHit = cmpQ.aboveOvp[ctrl_q.ovpSel];
   assign inputValidStatus = cmpQ.aboveUvlo & ~ovpHit;

   // ****************************************
   // APB decode
   // ****************************************
   // One wait state: pready rises on the second access cycle
   assign accessStart = psel & penable & ~pready;
   assign accessDone = psel & penable & pready;
   assign ctrlHit = paddr == charger_supervisor_pkg::CTRL_OFFSET;
   assign statusHit = paddr == charger_supervisor_pkg::STATUS_OFFSET;
   assign ctrlWriteDone = accessDone & pwrite & ctrlHit & pstrb[0];
   assign statusReadDone = accessDone & ~pwrite & statusHit;

   always_comb begin
      readWord = '0;
      if (ctrlHit) begin
         readWord = ctrl_word(ctrl_q);
      end else if (statusHit) begin
         // A set in the sampling cycle is reported, so the clear loses none
         readWord[charger_supervisor_pkg::STS_IRQ_FLAG_BIT] =
            inputIrqFlag_q | irqSet;
         readWord[charger_supervisor_pkg::STS_VALID_BIT] =
            inputValidStatus;
         readWord[charger_supervisor_pkg::STS_WALL_BIT] =
            cmpQ.supplyType;
         readWord[charger_supervisor_pkg::STS_CHG_EN_BIT] = chargeEnable;
         readWord[charger_supervisor_pkg::STS_OVP_LOCK_BIT] = ovpLock_q;
         readWord[charger_supervisor_pkg::STS_UV_LOCK_BIT] = uvLock_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (ce) begin
         pready <= accessStart;
         pslverr <= accessStart & ~ctrlHit & ~statusHit;
         if (accessStart & ~pwrite) begin
            prdata <= readWord;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q.ovpSel <= charger_supervisor_pkg::ovp_sel_t'(
            charger_supervisor_pkg::OVP_SEL_RESET);
         ctrl_q.statEn <= charger_supervisor_pkg::STAT_EN_RESET;
         ctrl_q.conEn <= charger_supervisor_pkg::CON_EN_RESET;
         ctrl_q.disEn <= charger_supervisor_pkg::DIS_EN_RESET;
      end else if (ce && ctrlWriteDone) begin
         ctrl_q.ovpSel <= charger_supervisor_pkg::ovp_sel_t'(
            pwdata[charger_supervisor_pkg::CTRL_OVP_LSB +: 2]);
         ctrl_q.statEn <= pwdata[charger_supervisor_pkg::CTRL_STAT_EN_BIT];
         ctrl_q.conEn <= pwdata[charger_supervisor_pkg::CTRL_CON_EN_BIT];
         ctrl_q.disEn <= pwdata[charger_supervisor_pkg::CTRL_DIS_EN_BIT];
      end
   end

   // ****************************************
   // Protection lockouts
   // ****************************************
   // Lock holds past a later threshold change; only 6.0V releases it
   always_ff @(posedge clk) begin
      if (srst) begin
         ovpLock_q <= 1'b0;
      end else if (ce) begin
         if (ovpHit) begin
            ovpLock_q <= 1'b1;
         end else if (cmpQ.belowResume) begin
            ovpLock_q <= 1'b0;
         end
      end
   end

   // Starts locked so a charge cycle needs the restart level first
   always_ff @(posedge clk) begin
      if (srst) begin
         uvLock_q <= 1'b1;
      end else if (ce) begin
         if (!cmpQ.aboveUvlo) begin
            uvLock_q <= 1'b1;
         end else if (cmpQ.aboveRestart) begin
            uvLock_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chargeEnable <= 1'b0;
      end else if (ce) begin
         chargeEnable <= ~ovpHit & ~ovpLock_q & cmpQ.aboveUvlo &
            ~uvLock_q;
      end
   end

   // ****************************************
   // Current limits and power path
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         inputLimit <= charger_supervisor_pkg::LIM_100MA;
         chargeCurrent <= charger_supervisor_pkg::CHG_USB_LOW;
      end else if (ce) begin
         if (cmpQ.supplyType) begin
            inputLimit <= charger_supervisor_pkg::LIM_2A;
            chargeCurrent <= cmpQ.currentLevel ?
               charger_supervisor_pkg::CHG_CURRENT_SET_PIN_FULL :
               charger_supervisor_pkg::CHG_CURRENT_SET_PIN_DIV5;
         end else begin
            inputLimit <= cmpQ.currentLevel ?
               charger_supervisor_pkg::LIM_450MA :
               charger_supervisor_pkg::LIM_100MA;
            chargeCurrent <= cmpQ.currentLevel ?
               charger_supervisor_pkg::CHG_USB_HIGH :
               charger_supervisor_pkg::CHG_USB_LOW;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chargeReduce <= 1'b0;
         powerPath <= charger_supervisor_pkg::PATH_BATTERY;
         ovpSelOut <= charger_supervisor_pkg::OVP_6V6;
      end else if (ce) begin
         chargeReduce <= cmpQ.railDropped;
         ovpSelOut <= ctrl_q.ovpSel;
         if (!inputValidStatus) begin
            powerPath <= charger_supervisor_pkg::PATH_BATTERY;
         end else if (cmpQ.overload) begin
            powerPath <= charger_supervisor_pkg::PATH_BOTH;
         end else begin
            powerPath <= charger_supervisor_pkg::PATH_INPUT;
         end
      end
   end

   // ****************************************
   // Input interrupt
   // ****************************************
   assign irqSet = ctrl_q.statEn & ((connectQ & ctrl_q.conEn) |
      (disconnectQ & ctrl_q.disEn));

   // Set wins over the read clear
   always_ff @(posedge clk) begin
      if (srst) begin
         inputIrqFlag_q <= 1'b0;
      end else if (ce) begin
         inputIrqFlag_q <= irqSet | (inputIrqFlag_q & ~statusReadDone);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irqOutN <= 1'b1;
      end else if (ce) begin
         irqOutN <= ~(irqSet | (inputIrqFlag_q & ~statusReadDone));
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_connectEnabled;
      ce && connectQ && ctrl_q.statEn && ctrl_q.conEn;
   endsequence

   sequence s_flagRaised;
      s_connectEnabled ##1 ce;
   endsequence

   property p_ovpStop;
      ce && ovpHit |=> !chargeEnable;
   endproperty
   a_ovpStop: assert property (p_ovpStop)
      else $error("charging on during over-voltage");

   property p_ovpHold;
      ce && ovpLock_q && !cmpQ.belowResume |=> ovpLock_q ##1 !chargeEnable;
   endproperty
   a_ovpHold: assert property (p_ovpHold)
      else $error("over-voltage lock released above resume level");

   property p_usbLimit;
      ce && !cmpQ.supplyType |=> inputLimit ==
         ($past(cmpQ.currentLevel) ? charger_supervisor_pkg::LIM_450MA :
          charger_supervisor_pkg::LIM_100MA);
   endproperty
   a_usbLimit: assert property (p_usbLimit)
      else $error("wrong USB input limit");

   property p_acLimit;
      ce && cmpQ.supplyType |=> inputLimit == charger_supervisor_pkg::LIM_2A;
   endproperty
   a_acLimit: assert property (p_acLimit)
      else $error("wrong AC input limit");

   property p_acDiv5;
      ce && cmpQ.supplyType && !cmpQ.currentLevel |=>
         chargeCurrent == charger_supervisor_pkg::CHG_CURRENT_SET_PIN_DIV5;
   endproperty
   a_acDiv5: assert property (p_acDiv5)
      else $error("AC low level did not divide charge current");

   property p_uvStop;
      ce && !cmpQ.aboveUvlo |=> !chargeEnable && uvLock_q;
   endproperty
   a_uvStop: assert property (p_uvStop)
      else $error("charging on under-voltage");

   property p_railReduce;
      ce && cmpQ.railDropped |=> chargeReduce;
   endproperty
   a_railReduce: assert property (p_railReduce)
      else $error("charge current not reduced on rail drop");

   property p_batteryPath;
      ce && !inputValidStatus |=>
         powerPath == charger_supervisor_pkg::PATH_BATTERY;
   endproperty
   a_batteryPath: assert property (p_batteryPath)
      else $error("system not on battery without valid input");

   property p_connectIrq;
      s_flagRaised |-> inputIrqFlag_q && !irqOutN;
   endproperty
   a_connectIrq: assert property (p_connectIrq)
      else $error("connect interrupt not raised");

   property p_readClear;
      ce && statusReadDone && !irqSet |=> !inputIrqFlag_q && irqOutN;
   endproperty
   a_readClear: assert property (p_readClear)
      else $error("flag not cleared by read");

   property p_pinMatchesFlag;
      ce ##1 ce |-> irqOutN == !inputIrqFlag_q;
   endproperty
   a_pinMatchesFlag: assert property (p_pinMatchesFlag)
      else $error("interrupt pin disagrees with flag");

endmodule

`default_nettype wire

// file: logic/charger_supervisor_pkg.sv
package charger_supervisor_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // ****************************************
   // Control field positions and reset values
   // ****************************************
   localparam int CTRL_OVP_LSB = 0;
   localparam int CTRL_STAT_EN_BIT = 2;
   localparam int CTRL_CON_EN_BIT = 3;
   localparam int CTRL_DIS_EN_BIT = 4;
   localparam logic [1:0] OVP_SEL_RESET = 2'h0;
   localparam logic STAT_EN_RESET = 1'h0;
   localparam logic CON_EN_RESET = 1'h0;
   localparam logic DIS_EN_RESET = 1'h0;

   // ****************************************
   // Status field positions
   // ****************************************
   localparam int STS_IRQ_FLAG_BIT = 0;
   localparam int STS_VALID_BIT = 1;
   localparam int STS_WALL_BIT = 2;
   localparam int STS_CHG_EN_BIT = 3;
   localparam int STS_OVP_LOCK_BIT = 4;
   localparam int STS_UV_LOCK_BIT = 5;

   // ****************************************
   // Types
   // ****************************************
   // Over-voltage select: 6.6V, 7.0V, 7.5V, 8.0V
   typedef enum logic [1:0] {
      OVP_6V6 = 2'b00,
      OVP_7V0 = 2'b01,
      OVP_7V5 = 2'b10,
      OVP_8V0 = 2'b11
   } ovp_sel_t;

   typedef enum logic [1:0] {
      LIM_100MA = 2'b00,
      LIM_450MA = 2'b01,
      LIM_2A = 2'b10
   } in_limit_t;

   typedef enum logic [1:0] {
      CHG_USB_LOW = 2'b00,
      CHG_USB_HIGH = 2'b01,
      CHG_CURRENT_SET_PIN_DIV5 = 2'b10,
      CHG_CURRENT_SET_PIN_FULL = 2'b11
   } chg_cur_t;

   typedef enum logic [1:0] {
      PATH_BATTERY = 2'b00,
      PATH_INPUT = 2'b01,
      PATH_BOTH = 2'b10
   } path_t;

   // Analog comparator results, one bit each except aboveOvp, which has four
   typedef struct packed {
      logic [3:0] aboveOvp;      // Input above 6.6/7.0/7.5/8.0V, bit per code
      logic belowResume;         // Input below 6.0V
      logic aboveUvlo;           // Input above 3.5V
      logic aboveRestart;        // Input above 3.5V plus 500mV
      logic railDropped;         // System rail dropped more than 200mV
      logic overload;            // System demand above input capability
      logic supplyType;          // Supply-type input above 1.2V
      logic currentLevel;        // Current-level input
   } cmp_t;

   typedef struct packed {
      ovp_sel_t ovpSel;
      logic statEn;
      logic conEn;
      logic disEn;
   } ctrl_t;

endpackage

// file: logic/input_edge_reg.sv
`timescale 1ns/1ps
`default_nettype none

module input_edge_reg (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // Comparators and threshold choice
   input wire charger_supervisor_pkg::cmp_t cmpRaw,
   input wire charger_supervisor_pkg::ovp_sel_t ovpSel,
   // Registered results
   output charger_supervisor_pkg::cmp_t cmpQ,
   output logic validQ,
   output logic connectQ,
   output logic disconnectQ
);

   // ****************************************
   // Sampling and edge detection
   // ****************************************
   logic validNow;

   // Window test uses the already registered comparators
   assign validNow = cmpQ.aboveUvlo & ~cmpQ.aboveOvp[ovpSel];

   always_ff @(posedge clk) begin
      if (srst) begin
         cmpQ <= '0;
      end else if (ce) begin
         cmpQ <= cmpRaw;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         validQ <= 1'b0;
         connectQ <= 1'b0;
         disconnectQ <= 1'b0;
      end else if (ce) begin
         validQ <= validNow;
         connectQ <= validNow & ~validQ;
         disconnectQ <= ~validNow & validQ;
      end
   end

endmodule

`default_nettype wire

// file: bench/supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Input supply and host pin levels
// ****************************************
// Ideal comparators: the bench sets a voltage in mV and pin levels, and
// this model turns them into the levels the analog front end would give.
module supply_model (
   // Stimulus
   input var int inputMv,
   input wire logic supplyHigh,
   input wire logic levelHigh,
   input wire logic railLow,
   input wire logic overDemand,
   // Comparator results
   output charger_supervisor_pkg::cmp_t cmpOut
);
   always_comb begin
      cmpOut.aboveOvp[0] = (inputMv > 6600);
      cmpOut.aboveOvp[1] = (inputMv > 7000);
      cmpOut.aboveOvp[2] = (inputMv > 7500);
      cmpOut.aboveOvp[3] = (inputMv > 8000);
      cmpOut.belowResume = (inputMv < 6000);
      cmpOut.aboveUvlo = (inputMv > 3500);
      cmpOut.aboveRestart = (inputMv > 4000);
      cmpOut.railDropped = railLow;
      cmpOut.overload = overDemand;
      // Pin levels are held steady by the host between changes
      cmpOut.supplyType = supplyHigh;
      cmpOut.currentLevel = levelHigh;
   end
endmodule

`default_nettype wire

// file: bench/test_charger_input_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

module test_charger_input_supervisor;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, chargeEnable, chargeReduce, irqOutN;
   charger_supervisor_pkg::cmp_t cmpRaw;
   charger_supervisor_pkg::ovp_sel_t ovpSelOut;
   charger_supervisor_pkg::in_limit_t inputLimit;
   charger_supervisor_pkg::chg_cur_t chargeCurrent;
   charger_supervisor_pkg::path_t powerPath;
   int inputMv = 0;
   logic supplyHigh = 1'b0;
   logic levelHigh = 1'b0;
   logic railLow = 1'b0;
   logic overDemand = 1'b0;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;
   int thr[4] = '{6600, 7000, 7500, 8000};

   always #2 clk = ~clk;

   supply_model u_model (.inputMv(inputMv), .supplyHigh(supplyHigh),
      .levelHigh(levelHigh), .railLow(railLow), .overDemand(overDemand),
      .cmpOut(cmpRaw));

   charger_input_supervisor u_dut (.clk(clk), .srst(srst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmpRaw(cmpRaw), .chargeEnable(chargeEnable),
      .ovpSelOut(ovpSelOut), .inputLimit(inputLimit),
      .chargeCurrent(chargeCurrent), .chargeReduce(chargeReduce),
      .powerPath(powerPath), .irqOutN(irqOutN));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Master holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, input logic [3:0] be);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= be;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic status(input logic [31:0] exp, input string m);
      apb(1'b0, charger_supervisor_pkg::STATUS_OFFSET, 32'h0, 4'h0);
      chk(rd, exp, m);
   endtask

   // Comparator to output path is at most three registers deep
   task automatic volt(input int mv);
      @(posedge clk);
      inputMv <= mv;
      repeat (6) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("[FAIL] %0t timeout", $time);
         end_of_test();
      end
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({chargeEnable, irqOutN, pready, pslverr}, 4'h4, "rst pins");
      chk({ovpSelOut, inputLimit, chargeCurrent, powerPath}, 8'h0, "rst");
      apb(1'b0, charger_supervisor_pkg::CTRL_OFFSET, 32'h0, 4'h0);
      chk(rd, 32'h0, "ctrl reset");
      status(32'h20, "status reset");
      // Status enable alone must not report a connect
      apb(1'b1, charger_supervisor_pkg::CTRL_OFFSET, 32'h04, 4'h1);
      volt(5000);
      chk(irqOutN, 1'b1, "masked connect");
      chk(powerPath, charger_supervisor_pkg::PATH_INPUT, "path");
      status(32'h0a, "valid no irq");
      apb(1'b1, charger_supervisor_pkg::CTRL_OFFSET, 32'h1c, 4'h1);
      volt(3000);
      chk(irqOutN, 1'b0, "disconnect irq");
      chk(chargeEnable, 1'b0, "uvlo off");
      chk(powerPath, charger_supervisor_pkg::PATH_BATTERY, "batt");
      status(32'h21, "flag set");
      repeat (2) @(posedge clk);
      chk(irqOutN, 1'b1, "irq released");
      status(32'h20, "flag cleared");
      // Inside the restart margin: valid but still locked out
      volt(3800);
      chk(chargeEnable, 1'b0, "restart margin");
      status(32'h23, "connect irq");
      volt(4200);
      chk(chargeEnable, 1'b1, "restart");
      status(32'h0a, "running");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         supplyHigh <= i[1];
         levelHigh <= i[0];
         repeat (6) @(posedge clk);
         chk(inputLimit, i[1] ? 2'h2 : {1'b0, i[0]}, "in limit");
         chk(chargeCurrent, i[1:0], "chg cur");
         status({28'h0, 1'b1, i[1], 2'h2}, "wall");
      end
      @(posedge clk);
      supplyHigh <= 1'b0;
      railLow <= 1'b1;
      repeat (6) @(posedge clk);
      chk(chargeReduce, 1'b1, "rail drop");
      railLow <= 1'b0;
      overDemand <= 1'b1;
      repeat (6) @(posedge clk);
      chk(chargeReduce, 1'b0, "rail ok");
      chk(powerPath, charger_supervisor_pkg::PATH_BOTH, "both");
      overDemand <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, charger_supervisor_pkg::CTRL_OFFSET, 32'h1c | k, 4'h1);
         volt(thr[k] - 100);
         chk(chargeEnable, 1'b1, "below ovp");
         volt(thr[k] + 100);
         chk(ovpSelOut, k[1:0], "ovp sel");
         chk(chargeEnable, 1'b0, "ovp off");
         status(32'h11, "ovp status");
         volt(thr[k] - 100);
         chk(chargeEnable, 1'b0, "ovp lock");
         status(32'h13, "lock status");
         volt(5000);
         chk(chargeEnable, 1'b1, "ovp resume");
         status(32'h0a, "resumed");
      end
      // Unmapped place, masked write and read-only status
      apb(1'b0, 8'h08, 32'h0, 4'h0);
      chk(err, 1'b1, "unmapped err");
      chk(rd, 32'h0, "unmapped data");
      apb(1'b1, charger_supervisor_pkg::CTRL_OFFSET, 32'h0, 4'h0);
      apb(1'b0, charger_supervisor_pkg::CTRL_OFFSET, 32'h0, 4'h0);
      chk(err, 1'b0, "strobe off err");
      chk(rd, 32'h1f, "strobe off");
      apb(1'b1, charger_supervisor_pkg::STATUS_OFFSET, 32'hff, 4'hf);
      chk(err, 1'b0, "ro write");
      status(32'h0a, "ro kept");
      // Enable low must hold chargeEnable and irqOutN through an input drop
      ce <= 1'b0;
      inputMv <= 3000;
      repeat (6) @(posedge clk);
      chk({chargeEnable, irqOutN}, 2'h3, "frozen");
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      chk({chargeEnable, irqOutN}, 2'h0, "thawed");
      end_of_test();
   end
endmodule

`default_nettype wire
